// *** hdl/drp_regs.svh ***
`ifndef DRP_REGS_SVH
`define DRP_REGS_SVH

// ----------------------------------------------------------------
// Build and widths
// ----------------------------------------------------------------
`define DRP_CLK_MHZ 100
`define DRP_ECC_BUILD 1'b1
`define DRP_RBUF_DEPTH 512
`define DRP_RBUF_AW 9
`define DRP_WORD_W 72
`define DRP_DATA_W 64
`define DRP_CODE_W 8
`define DRP_ADDR_W 27
`define DRP_RQ_DEPTH 4
`define DRP_CMD_READ 3'h1

// ----------------------------------------------------------------
// Timing, in clocks unless named _NS; DRP_RBUF_MARGIN is in read buffer words
// ----------------------------------------------------------------
// Memory commands launch from a register on the rising edge, so 8 full
// cycles here show up as 8 clocks on the memory pins.
`define DRP_EMPTY_TO_CMD 8
`define DRP_PRE_TO_ACT 4
`define DRP_ACT_TO_RD 4
`define DRP_REFI_NS 7800
`define DRP_REFI_CYC ((`DRP_REFI_NS * `DRP_CLK_MHZ) / 1000)
`define DRP_RFC_NS 128
`define DRP_RFC_CYC ((`DRP_RFC_NS * `DRP_CLK_MHZ + 999) / 1000)
`define DRP_CAL_TIMEOUT 5'h1f
`define DRP_RBUF_MARGIN 8

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DRP_REG_CTRL 8'h00
`define DRP_REG_STATUS 8'h04
`define DRP_CTRL_ECC_BIT 0
`define DRP_CTRL_BANK_BIT 1
`define DRP_CTRL_CAS_LSB 4
`define DRP_CTRL_ECC_RESET 1'b1
`define DRP_CTRL_BANK_RESET 1'b1
`define DRP_CTRL_CAS_RESET 3'h5
`define DRP_STAT_CAL_BIT 0
`define DRP_STAT_ECC_BIT 1
`define DRP_STAT_LAT_LSB 8
`define DRP_STAT_RQ_LSB 16

`endif

// *** hdl/drp_pkg.sv ***
package drp_pkg;
`include "drp_regs.svh"

	typedef logic [`DRP_ADDR_W-1:0] drp_addr_t;

	typedef enum logic [2:0] {
		DRP_NOP = 3'b000,
		DRP_PRE = 3'b001,
		DRP_ACT = 3'b010,
		DRP_RD = 3'b011,
		DRP_REF = 3'b100
	} drp_mem_cmd_e;

	typedef enum logic [2:0] {
		ST_CAL = 3'b000,
		ST_CAL_WAIT = 3'b001,
		ST_IDLE = 3'b010,
		ST_WAIT = 3'b011,
		ST_RFC = 3'b100
	} drp_state_e;

	typedef struct packed {
		drp_state_e st;
		logic [4:0] cnt;
		drp_mem_cmd_e pend;
		logic ref_mode;
		logic ref_due;
		logic [9:0] refi;
		drp_addr_t cur;
		logic [`DRP_RQ_DEPTH-1:0][`DRP_ADDR_W-1:0] rq_addr;
		logic [`DRP_RQ_DEPTH-1:0][2:0] rq_cmd;
		logic [2:0] rq_wp;
		logic [2:0] rq_rp;
		logic [7:0] open_v;
		logic [7:0][13:0] open_row;
		logic [31:0] pipe;
		logic [4:0] lat;
		logic [4:0] board;
		logic cal_done;
		logic [`DRP_RBUF_AW:0] bwp;
		logic [`DRP_RBUF_AW:0] brp;
		logic inflight;
		logic [`DRP_WORD_W-1:0] hold;
		logic hold_v;
		logic [1:0][`DRP_DATA_W-1:0] sk_data;
		logic [1:0] sk_err;
		logic [1:0] sk_cnt;
		logic ecc_en;
		logic bank_en;
		logic [2:0] cas;
		logic ecc_err;
		logic ack;
		logic [31:0] dat;
		drp_mem_cmd_e mcmd;
		logic [2:0] mbank;
		logic [13:0] mrow;
		logic [9:0] mcol;
		logic mall;
	} drp_state_s;

	function automatic logic [2:0] drp_bank(input drp_addr_t a);
		return a[26:24];
	endfunction : drp_bank

	function automatic logic [13:0] drp_row(input drp_addr_t a);
		return a[23:10];
	endfunction : drp_row

	function automatic logic [9:0] drp_col(input drp_addr_t a);
		return a[9:0];
	endfunction : drp_col

	// One parity bit per payload byte lane
	function automatic logic [7:0] drp_check_code(input logic [63:0] w);
		logic [7:0] c;
		c = '0;
		for (int i = 0; i < 8; i++) begin
			c[i] = ^w[8*i +: 8];
		end
		return c;
	endfunction : drp_check_code

endpackage : drp_pkg

// *** hdl/drp_rbuf_if.sv ***
`timescale 1ns/10ps
interface drp_rbuf_if;
	logic wr_en;
	logic [8:0] wr_addr;
	logic [71:0] wr_data;
	logic rd_en;
	logic [8:0] rd_addr;
	logic [71:0] rd_data;
	modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
		input rd_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
		output rd_data);
endinterface : drp_rbuf_if

// *** hdl/drp_rbuf_mem.sv ***
`timescale 1ns/10ps
module drp_rbuf_mem (
	// Clock
	input wire logic core_clk,
	// Buffer port
	drp_rbuf_if.mem port
);
	logic [71:0] mem_q [0:511];

	// Read data is registered: it appears one clock after rd_en
	always_ff @(posedge core_clk) begin
		if (port.wr_en) begin
			mem_q[port.wr_addr] <= port.wr_data;
		end
		if (port.rd_en) begin
			port.rd_data <= mem_q[port.rd_addr];
		end
	end
endmodule : drp_rbuf_mem

// *** hdl/drp_read_path.sv ***
// How it works
// - ECC build buffers read words in a 512x72 memory; otherwise one register.
// - Each buffered word is 64 payload bits plus 8 check bits.
// - With the check enabled, every buffered word read out is checked.
// - Requests are popped, decoded, and reads issued at the queued address.
// - Read latency is measured first, then used to capture returned data.
// - Capture delay follows the configured CAS latency once calibrated.
// - Valid strobe marks available data, shown on the read word output.
// - Latency runs from the request push to the first word out.
// - Open-row read: empty low +1, read +8, then data.
// - Row conflict: precharge +8, activate +4, read +4.
// - With bank management, an open matching row skips the activate.
// - Periodic auto-refresh closes all rows and preempts queued work.
// - Commands launch from registers on the rising clock edge, in whole cycles.
`timescale 1ns/10ps
`include "drp_regs.svh"
module drp_read_path
	import drp_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Wishbone slave
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	// Request queue
	input wire logic request_queue_push,
	input wire drp_pkg::drp_addr_t request_target_address,
	input wire logic [2:0] request_command_code,
	output logic request_queue_almost_full,
	output logic request_queue_empty,
	// Read words to user
	output logic read_word_valid,
	output logic [63:0] read_word_data,
	output logic read_word_ecc_error,
	input wire logic read_word_ready,
	// Memory commands
	output drp_pkg::drp_mem_cmd_e mem_cmd,
	output logic [2:0] mem_bank,
	output logic [13:0] mem_row,
	output logic [9:0] mem_col,
	output logic mem_precharge_all,
	// Memory read return
	input wire logic [71:0] mem_rd_data,
	input wire logic mem_rd_strobe
);
	import drp_pkg::*;

	// ----------------------------------------------------------------
	// Read buffer
	// ----------------------------------------------------------------
	drp_rbuf_if rbuf ();

	generate
		if (`DRP_ECC_BUILD) begin : g_ecc
			drp_rbuf_mem u_mem (
				.core_clk(core_clk),
				.port(rbuf.mem)
			);
		end else begin : g_plain
			assign rbuf.rd_data = '0;
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	drp_state_s q;
	drp_state_s d;

	logic [2:0] rq_count;
	logic rq_full;
	logic [`DRP_RBUF_AW:0] rbuf_count;
	logic [1:0] occupancy;
	logic read_room;
	logic [4:0] cap_delay;

	assign rq_count = q.rq_wp - q.rq_rp;
	assign rq_full = rq_count == 3'(`DRP_RQ_DEPTH);
	assign rbuf_count = q.bwp - q.brp;
	assign occupancy = q.sk_cnt + {1'b0, q.inflight};
	assign cap_delay = {2'b00, q.cas} + q.board;

	// Only start a read when its word is sure to find a place
	always_comb begin
		if (`DRP_ECC_BUILD) begin
			read_room = rbuf_count <
				10'(`DRP_RBUF_DEPTH - `DRP_RBUF_MARGIN);
		end else begin
			read_room = (q.pipe == '0) && !q.hold_v && (q.sk_cnt == 2'h0);
		end
	end

	assign request_queue_empty = rq_count == 3'h0;
	assign request_queue_almost_full =
		rq_count >= 3'(`DRP_RQ_DEPTH - 1);
	assign read_word_valid = q.sk_cnt != 2'h0;
	assign read_word_data = q.sk_data[0];
	assign read_word_ecc_error = q.sk_err[0];
	assign wb_ack = q.ack;
	assign wb_dat_r = q.dat;
	assign mem_cmd = q.mcmd;
	assign mem_bank = q.mbank;
	assign mem_row = q.mrow;
	assign mem_col = q.mcol;
	assign mem_precharge_all = q.mall;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] cnt_after;
		logic push_v;
		logic [`DRP_WORD_W-1:0] push_w;
		logic push_err;
		logic [2:0] bank;
		cnt_after = '0;
		push_v = 1'b0;
		push_w = '0;
		push_err = 1'b0;
		bank = '0;
		d = q;
		rbuf.wr_en = 1'b0;
		rbuf.wr_addr = q.bwp[`DRP_RBUF_AW-1:0];
		rbuf.wr_data = mem_rd_data;
		rbuf.rd_en = 1'b0;
		rbuf.rd_addr = q.brp[`DRP_RBUF_AW-1:0];
		d.mcmd = DRP_NOP;
		d.mall = 1'b0;
		d.ack = 1'b0;
		d.inflight = 1'b0;
		d.pipe = {q.pipe[30:0], 1'b0};

		// Wishbone: answer one clock after the request is seen
		if (wb_cyc && wb_stb && !q.ack) begin
			d.ack = 1'b1;
			d.dat = '0;
			unique case (wb_adr)
				`DRP_REG_CTRL: begin
					d.dat[`DRP_CTRL_ECC_BIT] = q.ecc_en;
					d.dat[`DRP_CTRL_BANK_BIT] = q.bank_en;
					d.dat[`DRP_CTRL_CAS_LSB +: 3] = q.cas;
				end
				`DRP_REG_STATUS: begin
					d.dat[`DRP_STAT_CAL_BIT] = q.cal_done;
					d.dat[`DRP_STAT_ECC_BIT] = q.ecc_err;
					d.dat[`DRP_STAT_LAT_LSB +: 5] = q.lat;
					d.dat[`DRP_STAT_RQ_LSB +: 3] = rq_count;
				end
				default: d.dat = '0;
			endcase
		end

		// Writes land only at the edge where ack is seen high
		if (wb_cyc && wb_stb && wb_we && wb_sel[0] && q.ack) begin
			if (wb_adr == `DRP_REG_CTRL) begin
				d.ecc_en = wb_dat_w[`DRP_CTRL_ECC_BIT];
				d.bank_en = wb_dat_w[`DRP_CTRL_BANK_BIT];
				d.cas = wb_dat_w[`DRP_CTRL_CAS_LSB +: 3];
			end
			if (wb_adr == `DRP_REG_STATUS &&
				wb_dat_w[`DRP_STAT_ECC_BIT]) begin
				d.ecc_err = 1'b0;
			end
		end

		// Request queue push; a push into a full queue is dropped
		if (request_queue_push && !rq_full) begin
			d.rq_addr[q.rq_wp[1:0]] = request_target_address;
			d.rq_cmd[q.rq_wp[1:0]] = request_command_code;
			d.rq_wp = q.rq_wp + 3'h1;
		end

		// Two-entry output buffer: user side
		cnt_after = q.sk_cnt;
		if (q.sk_cnt != 2'h0 && read_word_ready) begin
			d.sk_data[0] = q.sk_data[1];
			d.sk_err[0] = q.sk_err[1];
			cnt_after = q.sk_cnt - 2'h1;
		end

		// Two-entry output buffer: fill side
		if (`DRP_ECC_BUILD) begin
			push_v = q.inflight;
			push_w = rbuf.rd_data;
		end else begin
			push_v = q.hold_v && (q.sk_cnt != 2'h2);
			push_w = q.hold;
			if (push_v) begin
				d.hold_v = 1'b0;
			end
		end
		push_err = `DRP_ECC_BUILD && q.ecc_en &&
			(drp_check_code(push_w[63:0]) != push_w[71:64]);
		if (push_v) begin
			d.sk_data[cnt_after[0]] = push_w[63:0];
			d.sk_err[cnt_after[0]] = push_err;
			cnt_after = cnt_after + 2'h1;
		end
		d.sk_cnt = cnt_after;
		if (push_v && push_err) begin
			d.ecc_err = 1'b1;
		end

		// Read buffer drain; a word in flight counts as occupied
		if (`DRP_ECC_BUILD && rbuf_count != '0 && occupancy < 2'h2) begin
			rbuf.rd_en = 1'b1;
			d.brp = q.brp + 10'h1;
			d.inflight = 1'b1;
		end

		// Capture at the calibrated delay, not on the data strobe
		if (q.cal_done && q.pipe[cap_delay]) begin
			if (`DRP_ECC_BUILD) begin
				rbuf.wr_en = 1'b1;
				d.bwp = q.bwp + 10'h1;
			end else begin
				d.hold = mem_rd_data;
				d.hold_v = 1'b1;
			end
		end

		// Command sequencer
		unique case (q.st)
			ST_CAL: begin
				d.mcmd = DRP_RD;
				d.mbank = '0;
				d.mrow = '0;
				d.mcol = '0;
				d.cnt = '0;
				d.st = ST_CAL_WAIT;
			end
			ST_CAL_WAIT: begin
				if (mem_rd_strobe) begin
					d.lat = q.cnt;
					d.board = (q.cnt > {2'b00, q.cas}) ?
						q.cnt - {2'b00, q.cas} : 5'h0;
					d.cal_done = 1'b1;
					d.st = ST_IDLE;
				end else if (q.cnt == `DRP_CAL_TIMEOUT) begin
					d.st = ST_CAL;
				end else begin
					d.cnt = q.cnt + 5'h1;
				end
			end
			ST_IDLE: begin
				if (q.ref_due) begin
					d.ref_due = 1'b0;
					d.ref_mode = 1'b1;
					d.pend = (q.open_v != '0) ? DRP_PRE : DRP_REF;
					d.cnt = '0;
					d.st = ST_WAIT;
				end else if (rq_count != 3'h0 && read_room) begin
					d.rq_rp = q.rq_rp + 3'h1;
					if (q.rq_cmd[q.rq_rp[1:0]] == `DRP_CMD_READ) begin
						d.cur = q.rq_addr[q.rq_rp[1:0]];
						bank = drp_bank(d.cur);
						if (!q.bank_en) begin
							d.pend = DRP_PRE;
						end else if (!q.open_v[bank]) begin
							d.pend = DRP_ACT;
						end else if (q.open_row[bank] == drp_row(d.cur)) begin
							d.pend = DRP_RD;
						end else begin
							d.pend = DRP_PRE;
						end
						d.cnt = 5'(`DRP_EMPTY_TO_CMD - 2);
						d.st = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (q.cnt != 5'h0) begin
					d.cnt = q.cnt - 5'h1;
				end else begin
					bank = drp_bank(q.cur);
					d.mcmd = q.pend;
					d.mbank = bank;
					d.mrow = drp_row(q.cur);
					d.mcol = drp_col(q.cur);
					unique case (q.pend)
						DRP_PRE: begin
							d.mall = q.ref_mode;
							if (q.ref_mode) begin
								d.open_v = '0;
								d.pend = DRP_REF;
							end else begin
								d.open_v[bank] = 1'b0;
								d.pend = DRP_ACT;
							end
							d.cnt = 5'(`DRP_PRE_TO_ACT - 1);
						end
						DRP_ACT: begin
							d.open_v[bank] = 1'b1;
							d.open_row[bank] = drp_row(q.cur);
							d.pend = DRP_RD;
							d.cnt = 5'(`DRP_ACT_TO_RD - 1);
						end
						DRP_RD: begin
							d.pipe[0] = 1'b1;
							d.st = ST_IDLE;
						end
						DRP_REF: begin
							d.ref_mode = 1'b0;
							d.cnt = 5'(`DRP_RFC_CYC - 2);
							d.st = ST_RFC;
						end
						default: d.st = ST_IDLE;
					endcase
				end
			end
			ST_RFC: begin
				if (q.cnt != 5'h0) begin
					d.cnt = q.cnt - 5'h1;
				end else begin
					d.st = ST_IDLE;
				end
			end
			default: d.st = ST_IDLE;
		endcase

		// Refresh interval; setting the request wins over its clear
		if (q.cal_done) begin
			if (q.refi == 10'h0) begin
				d.refi = 10'(`DRP_REFI_CYC - 1);
				d.ref_due = 1'b1;
			end else begin
				d.refi = q.refi - 10'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.refi <= 10'(`DRP_REFI_CYC - 1);
			q.ecc_en <= `DRP_CTRL_ECC_RESET;
			q.bank_en <= `DRP_CTRL_BANK_RESET;
			q.cas <= `DRP_CTRL_CAS_RESET;
		end else begin
			q <= d;
		end
	end
endmodule : drp_read_path

// *** verification/drp_mem_model.sv ***
`timescale 1ns/10ps
module drp_mem_model
	import drp_pkg::*;
#(
	parameter int LAT = 6
) (
	// Clock
	input wire logic core_clk,
	// Command side
	input wire drp_pkg::drp_mem_cmd_e mem_cmd,
	input wire logic [2:0] mem_bank,
	input wire logic [13:0] mem_row,
	input wire logic [9:0] mem_col,
	input wire logic corrupt,
	// Return side
	output logic [71:0] mem_rd_data,
	output logic mem_rd_strobe
);
	logic [27:0] pipe_q [LAT];
	logic [71:0] last_q;
	logic [63:0] pay;
	logic [7:0] code;

	initial begin
		last_q = '0;
		for (int i = 0; i < LAT; i++) begin
			pipe_q[i] = '0;
		end
	end

	// Payload follows the address so every word can be traced
	always_comb begin
		pay = {~pipe_q[LAT-1][26:0], 10'h3c5, pipe_q[LAT-1][26:0]};
		for (int i = 0; i < 8; i++) begin
			code[i] = ^pay[8*i +: 8];
		end
		mem_rd_strobe = pipe_q[LAT-1][27];
		// Outside the strobe the bus shows its previous value inverted, so a word is valid only in its strobe cycle
		if (mem_rd_strobe) begin
			mem_rd_data = {code ^ {7'h00, corrupt}, pay};
		end else begin
			mem_rd_data = ~last_q;
		end
	end

	always @(posedge core_clk) begin
		pipe_q[0] <= {mem_cmd == DRP_RD, mem_bank, mem_row, mem_col};
		for (int i = 1; i < LAT; i++) begin
			pipe_q[i] <= pipe_q[i-1];
		end
		last_q <= mem_rd_data;
	end
endmodule : drp_mem_model

// *** verification/drp_read_path_sva.sv ***
`timescale 1ns/10ps
module drp_read_path_sva
	import drp_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Register bus
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_ack,
	// Request queue
	input wire logic request_queue_push,
	input wire logic request_queue_almost_full,
	input wire logic request_queue_empty,
	// Read words
	input wire logic read_word_valid,
	input wire logic read_word_ready,
	input wire logic [63:0] read_word_data,
	// Memory commands
	input wire drp_pkg::drp_mem_cmd_e mem_cmd,
	input wire logic mem_precharge_all
);
	default clocking dcb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_act_rd;
		mem_cmd == DRP_ACT ##4 mem_cmd == DRP_RD;
	endsequence
	sequence s_close_all;
		mem_cmd == DRP_PRE && mem_precharge_all;
	endsequence

	ack_answer_a:
	assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
		else $error("bus request not answered next cycle");
	ack_pulse_a:
	assert property (wb_ack |=> !wb_ack)
		else $error("bus ack longer than one cycle");
	queue_fill_a:
	assert property (request_queue_push && !request_queue_almost_full
		|=> !request_queue_empty)
		else $error("queue stayed empty after push");
	flags_agree_a:
	assert property (request_queue_empty |-> !request_queue_almost_full)
		else $error("almost full while empty");
	read_gap_a:
	assert property (mem_cmd == DRP_RD |=> (mem_cmd != DRP_RD) [*7])
		else $error("reads closer than eight cycles");
	pre_act_a:
	assert property (mem_cmd == DRP_PRE && !mem_precharge_all
		|-> ##4 s_act_rd)
		else $error("precharge not followed by activate and read");
	act_read_a:
	assert property (mem_cmd == DRP_ACT |-> ##4 mem_cmd == DRP_RD)
		else $error("activate not followed by read");
	refresh_close_a:
	assert property (s_close_all |-> ##[1:16] mem_cmd == DRP_REF)
		else $error("close of all rows without refresh");
	word_hold_a:
	assert property (read_word_valid && !read_word_ready
		|=> read_word_valid && $stable(read_word_data))
		else $error("stalled read word changed or vanished");
endmodule : drp_read_path_sva

bind drp_read_path drp_read_path_sva u_sva (
	.core_clk(core_clk), .resetn(resetn), .wb_cyc(wb_cyc),
	.wb_stb(wb_stb), .wb_ack(wb_ack),
	.request_queue_push(request_queue_push),
	.request_queue_almost_full(request_queue_almost_full),
	.request_queue_empty(request_queue_empty),
	.read_word_valid(read_word_valid), .read_word_ready(read_word_ready),
	.read_word_data(read_word_data), .mem_cmd(mem_cmd),
	.mem_precharge_all(mem_precharge_all)
);

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	error_cnt++; $display("wrong value %s expected %0h seen %0h", n, e, s); \
	end end
module testbench;
	import drp_pkg::*;
	localparam int LAT = 6;
	localparam drp_addr_t A = {3'h2, 14'h0123, 10'h010};
	logic core_clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, push, af, empty;
	logic valid, ecc_err, ready, strobe, corrupt, pall, saw_all;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, rd;
	logic [2:0] code, mem_bank;
	logic [13:0] mem_row;
	logic [9:0] mem_col;
	logic [63:0] rdata;
	logic [71:0] mdata;
	drp_addr_t tgt;
	drp_mem_cmd_e mem_cmd;
	int error_cnt, comparisons;

	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end

	drp_read_path uut (.core_clk(core_clk), .resetn(resetn),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack), .request_queue_push(push),
		.request_target_address(tgt), .request_command_code(code),
		.request_queue_almost_full(af), .request_queue_empty(empty),
		.read_word_valid(valid), .read_word_data(rdata),
		.read_word_ecc_error(ecc_err), .read_word_ready(ready),
		.mem_cmd(mem_cmd), .mem_bank(mem_bank), .mem_row(mem_row),
		.mem_col(mem_col), .mem_precharge_all(pall),
		.mem_rd_data(mdata), .mem_rd_strobe(strobe));

	drp_mem_model #(.LAT(LAT)) pm (.core_clk(core_clk), .mem_cmd(mem_cmd),
		.mem_bank(mem_bank), .mem_row(mem_row), .mem_col(mem_col),
		.corrupt(corrupt), .mem_rd_data(mdata), .mem_rd_strobe(strobe));

	always @(negedge core_clk) begin
		if (mem_cmd === DRP_PRE && pall === 1'b1) begin
			saw_all = 1;
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	task hang;
		error_cnt++;
		$display("wait ran out");
		wrap_up();
	endtask : hang

	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		wb_cyc <= 1;
		wb_stb <= 1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			hang();
		end
		rd = wb_dat_r;
		wb_cyc <= 0;
		wb_stb <= 0;
	endtask : wb

	task push_req(input drp_addr_t a, input logic [2:0] c);
		@(negedge core_clk);
		`CHK("almost full", 1'b0, af)
		@(posedge core_clk);
		push <= 1;
		tgt <= a;
		code <= c;
		@(posedge core_clk);
		push <= 0;
		@(negedge core_clk);
		`CHK("queue empty", 1'b0, empty)
	endtask : push_req

	task at_cmd(input int n, input drp_mem_cmd_e c);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
		`CHK("memory command", c, mem_cmd)
	endtask : at_cmd

	// Kind 0 open row, 1 closed bank, 2 precharge first
	task timed(input drp_addr_t a, input int k);
		push_req(a, 3'h1);
		if (k == 2) begin
			at_cmd(8, DRP_PRE);
		end
		if (k != 0) begin
			at_cmd(k == 2 ? 4 : 8, DRP_ACT);
		end
		at_cmd(k == 0 ? 8 : 4, DRP_RD);
		`CHK("read address", a, {mem_bank, mem_row, mem_col})
		repeat (LAT + 3) @(posedge core_clk);
		@(negedge core_clk);
		`CHK("word valid", 1'b1, valid)
		`CHK("word data", {~a, 10'h3c5, a}, rdata)
	endtask : timed

	// Start timed work just after a refresh, so none lands inside it
	task wait_ref(input logic open_rows);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (mem_cmd !== DRP_REF && n < 1000);
		if (n >= 1000) begin
			hang();
		end
		`CHK("rows closed", open_rows, saw_all)
		saw_all = 0;
		repeat (20) @(posedge core_clk);
	endtask : wait_ref

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs;
		int n;
		wb(0, 8'h00, 0);
		`CHK("control reset", 32'h53, rd)
		n = 0;
		do begin
			wb(0, 8'h04, 0);
			n++;
		end while (rd[0] !== 1'b1 && n < 50);
		if (rd[0] !== 1'b1) begin
			hang();
		end
		`CHK("measured latency", 5'(LAT), rd[12:8])
		wb(1, 8'h10, 32'hff);
		wb(0, 8'h10, 0);
		`CHK("unmapped read", 32'h0, rd)
		wb(0, 8'h00, 0);
		`CHK("control kept", 32'h53, rd)
		$display("registers done");
	endtask : t_regs

	task t_rows;
		int n;
		wait_ref(1'b0);
		timed(A, 1);
		timed(A + 27'h10, 0);
		timed(A ^ 27'h00ff000, 2);
		push_req(A, 3'h2);
		n = 0;
		repeat (12) begin
			@(negedge core_clk);
			n += (mem_cmd !== DRP_NOP);
		end
		`CHK("commands for other code", 0, n)
		`CHK("queue drained", 1'b1, empty)
		$display("row cases done");
	endtask : t_rows

	task t_bank_off;
		wb(1, 8'h00, 32'h51);
		wait_ref(1'b1);
		timed(A, 2);
		timed(A, 2);
		wb(1, 8'h00, 32'h53);
		$display("bank management off done");
	endtask : t_bank_off

	task t_ecc(input logic en);
		wb(1, 8'h00, {28'h5, 3'h1, en});
		corrupt <= 1;
		ready <= 0;
		wait_ref(1'b1);
		timed(A, 1);
		`CHK("check error", en, ecc_err)
		wb(0, 8'h04, 0);
		`CHK("sticky error", en, rd[1])
		wb(1, 8'h04, 32'h2);
		wb(0, 8'h04, 0);
		`CHK("error cleared", 1'b0, rd[1])
		ready <= 1;
		corrupt <= 0;
		repeat (2) @(posedge core_clk);
		wb(1, 8'h00, 32'h53);
		$display("check code done");
	endtask : t_ecc

	task t_stall;
		int n;
		ready <= 0;
		wait_ref(1'b1);
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			push <= 1;
			tgt <= A + 27'(i);
			code <= 3'h1;
		end
		@(posedge core_clk);
		push <= 0;
		repeat (60) @(posedge core_clk);
		ready <= 1;
		// A drained pair may leave a one-cycle gap before the third word
		for (int i = 0; i < 3; i++) begin
			n = 0;
			@(negedge core_clk);
			while (valid !== 1'b1 && n < 4) begin
				@(negedge core_clk);
				n++;
			end
			if (valid !== 1'b1) begin
				hang();
			end
			`CHK("stalled valid", 1'b1, valid)
			`CHK("stalled data", {~(A + 27'(i)), 10'h3c5, A + 27'(i)}, rdata)
			@(posedge core_clk);
		end
		@(negedge core_clk);
		`CHK("buffer empty", 1'b0, valid)
		$display("stall done");
	endtask : t_stall

	initial begin
		resetn = 0;
		wb_cyc = 0;
		wb_stb = 0;
		wb_we = 0;
		wb_adr = '0;
		wb_sel = 4'h1;
		wb_dat_w = '0;
		push = 0;
		tgt = '0;
		code = '0;
		ready = 1;
		corrupt = 0;
		saw_all = 0;
		error_cnt = 0;
		comparisons = 0;
		@(negedge core_clk);
		`CHK("valid in reset", 1'b0, valid)
		`CHK("empty in reset", 1'b1, empty)
		`CHK("command in reset", DRP_NOP, mem_cmd)
		@(posedge core_clk);
		resetn <= 1;
		t_regs();
		t_rows();
		t_bank_off();
		t_ecc(1);
		t_ecc(0);
		t_stall();
		wrap_up();
	end
endmodule : testbench
